// ==== inc/ircd_pkg.sv ====
// Constants for the resource configuration register bank and its decoders
package ircd_pkg;

	// ----------------------------------------------------------------
	// Register indices
	// ----------------------------------------------------------------
	localparam logic [7:0] IRCD_ACTIVATE     = 8'h30;
	localparam logic [7:0] IRCD_BOOT_BASE_HI = 8'h40;
	localparam logic [7:0] IRCD_BOOT_BASE_LO = 8'h41;
	localparam logic [7:0] IRCD_BOOT_WIDE    = 8'h42;
	localparam logic [7:0] IRCD_BOOT_SIZE_HI = 8'h43;
	localparam logic [7:0] IRCD_BOOT_SIZE_LO = 8'h44;
	localparam logic [7:0] IRCD_SRAM_BASE_HI = 8'h48;
	localparam logic [7:0] IRCD_SRAM_BASE_LO = 8'h49;
	localparam logic [7:0] IRCD_SRAM_WIDE    = 8'h4a;
	localparam logic [7:0] IRCD_SRAM_SIZE_HI = 8'h4b;
	localparam logic [7:0] IRCD_SRAM_SIZE_LO = 8'h4c;
	localparam logic [7:0] IRCD_IO_BASE_HI   = 8'h60;
	localparam logic [7:0] IRCD_IO_BASE_LO   = 8'h61;
	localparam logic [7:0] IRCD_IRQ_SELECT   = 8'h70;
	localparam logic [7:0] IRCD_IRQ_KIND     = 8'h71;
	localparam logic [7:0] IRCD_CHAN_SELECT  = 8'h74;

	// ----------------------------------------------------------------
	// Field positions and fixed bits
	// ----------------------------------------------------------------
	localparam int         IRCD_WIDE_BIT     = 1;
	localparam int         IRCD_LVL_BIT      = 1;
	localparam int         IRCD_TYPE_BIT     = 0;
	localparam int         IRCD_ACT_BIT      = 0;
	localparam logic [7:0] IRCD_IO_HI_FIXED  = 8'h02;
	localparam logic [7:0] IRCD_MEM_HI_FIXED = 8'h0c;
	localparam logic [7:0] IRCD_SZ_HI_FIXED  = 8'hfe;

	// ----------------------------------------------------------------
	// Values after reset
	// ----------------------------------------------------------------
	localparam logic [3:0] IRCD_IRQ_RESET    = 4'h3;
	localparam logic       IRCD_TYPE_RESET   = 1'b0;
	localparam logic [2:0] IRCD_CHAN_RESET   = 3'h4;
	localparam logic [3:0] IRCD_IO_RESET     = 4'h0;
	localparam logic [3:0] IRCD_BASE_RESET   = 4'h0;
	localparam logic [3:0] IRCD_SIZE_RESET   = 4'h0;

	// ----------------------------------------------------------------
	// ISA address decode
	// ----------------------------------------------------------------
	localparam logic [2:0] IRCD_ROM_REGION   = 3'h6;
	localparam logic       IRCD_IO_TOP       = 1'b1;
	localparam int         IRCD_SA_W         = 20;

endpackage

// ==== verilog/ircd_win.sv ====
// Memory window match for one base field against ISA address lines
`timescale 1ns/10ps
module ircd_win #(
	parameter int W = 4
) (
	input  wire logic [W-1:0] base,     // Base field
	input  wire logic [3:0]   size,     // Size field
	input  wire logic [W-1:0] addr,     // Address lines compared
	output logic              enabled,  // Size code is a valid window
	output logic              hit       // Address inside window
);
	logic [W-1:0] mask;

	generate
		if (W < 3 || W > 4) begin : g_bad_w
			$error("ircd_win: W must be 3 or 4");
		end
	endgenerate

	// Low three size bits are exactly the compare mask: 111 8K .. 000 64K
	always_comb begin
		mask = '1;
		mask[2:0] = size[2:0];
	end

	always_comb begin
		enabled = 1'b0;
		case (size)
			4'hf, 4'he, 4'hc, 4'h8: enabled = 1'b1;
			default: enabled = 1'b0;
		endcase
	end

	assign hit = enabled && (((base ^ addr) & mask) == '0);

endmodule

// ==== verilog/ircd_top.sv ====
// Resource configuration register bank with I/O, IRQ, DMA and memory decode
// Operation
// - I/O base field matches SA[8:5]
// - Serial EEPROM preloads base and channel fields
// - Interrupt select field value names IRQ line
// - Trigger kind bit: 1 level, 0 edge
// - Polarity flag reads complement of kind
// - No interrupt drive until activate set
// - Channel codes 011,101,110,111; 100 none
// - DRQ only bus master and activated
// - Boot ROM base field matches SA[16:13]
// - Boot ROM wide unless bus master
// - Boot ROM size field decode
// - Shared RAM low base bits match SA[15:13]
// - Shared RAM fields ignored outside shared mode
// - Shared RAM wide bit gives 16-bit answer
// - Shared RAM size field decode
// - Register 0x30 bit 0 activates device
`timescale 1ns/10ps
module ircd_top
	import ircd_pkg::*;
#(
	parameter int SA_W = IRCD_SA_W
) (
	input  wire logic            mclk,         // Device clock
	input  wire logic            nrst,         // Synchronous reset, active low
	input  wire logic [7:0]      cfg_index,    // Configuration register index
	input  wire logic [7:0]      cfg_wdata,    // Configuration write data
	input  wire logic            cfg_we,       // Configuration write strobe
	input  wire logic            cfg_re,       // Configuration read strobe
	output logic      [7:0]      cfg_rdata,    // Configuration read data
	input  wire logic [7:0]      ee_index,     // Preload register index
	input  wire logic [7:0]      ee_data,      // Preload data from EEPROM
	input  wire logic            ee_we,        // Preload write strobe
	input  wire logic            bus_master,   // Bus master architecture
	input  wire logic            pio_mode,     // Programmed I/O architecture
	input  wire logic [SA_W-1:0] sa,           // ISA system address
	input  wire logic            aen,          // Address enable, high for DMA
	input  wire logic            mem_cycle,    // Memory cycle in progress
	input  wire logic            irq_req,      // Interrupt request from core
	input  wire logic            dma_req,      // Transfer request from core
	output logic                 io_sel,       // I/O window selected
	output logic                 rom_sel,      // Boot ROM window selected
	output logic                 rom_cs16,     // Boot ROM answers 16-bit
	output logic                 ram_sel,      // Shared RAM window selected
	output logic                 ram_cs16,     // Shared RAM answers 16-bit
	output logic      [15:0]     irq_out,      // IRQ pin levels
	output logic      [15:0]     irq_oe_n,     // IRQ pin enables, low drives
	output logic      [7:0]      drq_out,      // DRQ pin levels
	output logic      [7:0]      drq_oe_n,     // DRQ pin enables, low drives
	output logic                 active        // Activate bit
);

	generate
		if (SA_W < IRCD_SA_W) begin : g_bad_sa_w
			$error("ircd_top: SA_W must cover 20 address lines");
		end
	endgenerate

	// ----------------------------------------------------------------
	// Decode functions
	// ----------------------------------------------------------------
	function automatic logic irq_valid(input logic [3:0] code);
		case (code)
			4'h3, 4'h4, 4'h5, 4'h9, 4'ha, 4'hb, 4'hc, 4'hf: irq_valid = 1'b1;
			default: irq_valid = 1'b0;
		endcase
	endfunction

	function automatic logic chan_valid(input logic [2:0] code);
		case (code)
			3'h3, 3'h5, 3'h6, 3'h7: chan_valid = 1'b1;
			default: chan_valid = 1'b0;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Configuration fields
	// ----------------------------------------------------------------
	logic [3:0] io_base_field;
	logic [3:0] irq_select;
	logic       irq_kind;
	logic [2:0] chan_select;
	logic [3:0] boot_rom_base_field;
	logic       boot_rom_wide;
	logic [3:0] boot_rom_size_field;
	logic [4:0] shared_ram_base;
	logic       shared_ram_wide;
	logic [3:0] shared_ram_size_field;
	logic       interrupt_polarity_flag;

	// EEPROM preload shares the host write path and wins a collision
	logic       wr;
	logic [7:0] wr_idx;
	logic [7:0] wr_dat;

	always_comb begin
		wr     = ee_we | cfg_we;
		wr_idx = ee_we ? ee_index : cfg_index;
		wr_dat = ee_we ? ee_data : cfg_wdata;
	end

	assign interrupt_polarity_flag = ~irq_kind;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			io_base_field <= IRCD_IO_RESET;
		end else if (wr && wr_idx == IRCD_IO_BASE_HI) begin
			io_base_field[3] <= wr_dat[0];
		end else if (wr && wr_idx == IRCD_IO_BASE_LO) begin
			io_base_field[2:0] <= wr_dat[7:5];
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			irq_select <= IRCD_IRQ_RESET;
			irq_kind   <= IRCD_TYPE_RESET;
		end else if (wr && wr_idx == IRCD_IRQ_SELECT) begin
			irq_select <= wr_dat[3:0];
		end else if (wr && wr_idx == IRCD_IRQ_KIND) begin
			// Polarity bit is derived, so only the kind bit is stored
			irq_kind <= wr_dat[IRCD_TYPE_BIT];
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			chan_select <= IRCD_CHAN_RESET;
		end else if (wr && wr_idx == IRCD_CHAN_SELECT) begin
			chan_select <= wr_dat[2:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			active <= 1'b0;
		end else if (wr && wr_idx == IRCD_ACTIVATE) begin
			active <= wr_dat[IRCD_ACT_BIT];
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			boot_rom_base_field <= IRCD_BASE_RESET;
			boot_rom_wide       <= 1'b0;
			boot_rom_size_field <= IRCD_SIZE_RESET;
		end else if (wr) begin
			case (wr_idx)
				IRCD_BOOT_BASE_HI: boot_rom_base_field[3]   <= wr_dat[0];
				IRCD_BOOT_BASE_LO: boot_rom_base_field[2:0] <= wr_dat[7:5];
				IRCD_BOOT_WIDE:    boot_rom_wide            <= wr_dat[IRCD_WIDE_BIT];
				IRCD_BOOT_SIZE_HI: boot_rom_size_field[3]   <= wr_dat[0];
				IRCD_BOOT_SIZE_LO: boot_rom_size_field[2:0] <= wr_dat[7:5];
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			shared_ram_base       <= {1'b0, IRCD_BASE_RESET};
			shared_ram_wide       <= 1'b0;
			shared_ram_size_field <= IRCD_SIZE_RESET;
		end else if (wr) begin
			case (wr_idx)
				IRCD_SRAM_BASE_HI: shared_ram_base[4:3]       <= wr_dat[1:0];
				IRCD_SRAM_BASE_LO: shared_ram_base[2:0]       <= wr_dat[7:5];
				IRCD_SRAM_WIDE:    shared_ram_wide            <= wr_dat[IRCD_WIDE_BIT];
				IRCD_SRAM_SIZE_HI: shared_ram_size_field[3]   <= wr_dat[0];
				IRCD_SRAM_SIZE_LO: shared_ram_size_field[2:0] <= wr_dat[7:5];
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Register read back
	// ----------------------------------------------------------------
	logic [7:0] next_rdata;

	always_comb begin
		next_rdata = 8'h00;
		case (cfg_index)
			IRCD_ACTIVATE:     next_rdata = {7'h00, active};
			IRCD_IO_BASE_HI:   next_rdata = IRCD_IO_HI_FIXED | {7'h00, io_base_field[3]};
			IRCD_IO_BASE_LO:   next_rdata = {io_base_field[2:0], 5'h00};
			IRCD_IRQ_SELECT:   next_rdata = {4'h0, irq_select};
			IRCD_IRQ_KIND:     next_rdata = {6'h00, interrupt_polarity_flag, irq_kind};
			IRCD_CHAN_SELECT:  next_rdata = {5'h00, chan_select};
			IRCD_BOOT_BASE_HI: next_rdata = IRCD_MEM_HI_FIXED | {7'h00, boot_rom_base_field[3]};
			IRCD_BOOT_BASE_LO: next_rdata = {boot_rom_base_field[2:0], 5'h00};
			IRCD_BOOT_WIDE:    next_rdata = {6'h00, boot_rom_wide, 1'b0};
			IRCD_BOOT_SIZE_HI: next_rdata = IRCD_SZ_HI_FIXED | {7'h00, boot_rom_size_field[3]};
			IRCD_BOOT_SIZE_LO: next_rdata = {boot_rom_size_field[2:0], 5'h00};
			IRCD_SRAM_BASE_HI: next_rdata = IRCD_MEM_HI_FIXED | {6'h00, shared_ram_base[4:3]};
			IRCD_SRAM_BASE_LO: next_rdata = {shared_ram_base[2:0], 5'h00};
			IRCD_SRAM_WIDE:    next_rdata = {6'h00, shared_ram_wide, 1'b0};
			IRCD_SRAM_SIZE_HI: next_rdata = IRCD_SZ_HI_FIXED | {7'h00, shared_ram_size_field[3]};
			IRCD_SRAM_SIZE_LO: next_rdata = {shared_ram_size_field[2:0], 5'h00};
			default:           next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!nrst)
			cfg_rdata <= 8'h00;
		else if (cfg_re)
			cfg_rdata <= next_rdata;
	end

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	logic rom_en;
	logic rom_hit;
	logic ram_en;
	logic ram_hit;
	logic shared_mode;

	ircd_win #(.W(4)) u_rom_win (
		.base    (boot_rom_base_field),
		.size    (boot_rom_size_field),
		.addr    (sa[16:13]),
		.enabled (rom_en),
		.hit     (rom_hit)
	);

	ircd_win #(.W(3)) u_ram_win (
		.base    (shared_ram_base[2:0]),
		.size    (shared_ram_size_field),
		.addr    (sa[15:13]),
		.enabled (ram_en),
		.hit     (ram_hit)
	);

	// Upper RAM base bits only describe external decode, never compared here
	assign shared_mode = !bus_master && !pio_mode;

	logic next_io_sel;
	logic next_rom_sel;
	logic next_ram_sel;

	always_comb begin
		next_io_sel  = active && !aen && sa[9] == IRCD_IO_TOP && sa[8:5] == io_base_field;
		next_rom_sel = active && mem_cycle && sa[19:17] == IRCD_ROM_REGION && rom_en && rom_hit;
		next_ram_sel = active && mem_cycle && shared_mode && ram_en && ram_hit;
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			io_sel   <= 1'b0;
			rom_sel  <= 1'b0;
			rom_cs16 <= 1'b0;
			ram_sel  <= 1'b0;
			ram_cs16 <= 1'b0;
		end else begin
			io_sel   <= next_io_sel;
			rom_sel  <= next_rom_sel;
			rom_cs16 <= next_rom_sel && boot_rom_wide && !bus_master;
			ram_sel  <= next_ram_sel;
			ram_cs16 <= next_ram_sel && shared_ram_wide;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt and transfer request pins
	// ----------------------------------------------------------------
	// Edge mode drives active high, level mode active low, as the flag reads
	logic irq_level;
	assign irq_level = irq_req ? interrupt_polarity_flag : ~interrupt_polarity_flag;

	genvar g;
	generate
		for (g = 0; g < 16; g++) begin : g_irq
			always_ff @(posedge mclk) begin
				if (!nrst) begin
					irq_out[g]  <= 1'b0;
					irq_oe_n[g] <= 1'b1;
				end else begin
					irq_out[g]  <= irq_level;
					irq_oe_n[g] <= !(active && irq_valid(irq_select) &&
						irq_select == 4'(g));
				end
			end
		end
		for (g = 0; g < 8; g++) begin : g_drq
			always_ff @(posedge mclk) begin
				if (!nrst) begin
					drq_out[g]  <= 1'b0;
					drq_oe_n[g] <= 1'b1;
				end else begin
					drq_out[g]  <= dma_req;
					drq_oe_n[g] <= !(active && bus_master && chan_valid(chan_select) &&
						chan_select == 3'(g));
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	sequence s_io_match;
		active && !aen && sa[9] && sa[8:5] == io_base_field;
	endsequence

	a_io_base_match: assert property (s_io_match |=> io_sel)
		else $error("io window not selected on match");

	a_io_no_match: assert property (!(active && !aen && sa[9] && sa[8:5] == io_base_field) |=> !io_sel)
		else $error("io window selected without match");

	a_irq_idle: assert property (!active |=> &irq_oe_n)
		else $error("irq driven while inactive");

	a_irq_line: assert property (active && irq_select == 4'h5 |=> !irq_oe_n[5] && $countones(~irq_oe_n) == 1)
		else $error("irq select 5 does not drive line 5 alone");

	a_irq_unlisted: assert property (irq_select == 4'h6 |=> &irq_oe_n)
		else $error("unlisted irq code drives a line");

	a_polarity_flag: assert property (cfg_re && cfg_index == IRCD_IRQ_KIND |=>
		cfg_rdata[IRCD_LVL_BIT] != cfg_rdata[IRCD_TYPE_BIT])
		else $error("polarity flag not complement of kind");

	a_edge_level: assert property (irq_req && irq_kind |=> irq_out == 16'h0000)
		else $error("level mode request not active low");

	a_drq_master: assert property (!bus_master || !active |=> &drq_oe_n)
		else $error("drq driven outside active bus master");

	a_drq_none: assert property (chan_select == 3'h4 |=> &drq_oe_n)
		else $error("channel code 100 drives a drq");

	a_rom_narrow: assert property (bus_master |=> !rom_cs16)
		else $error("boot rom 16-bit in bus master");

	a_ram_ignored: assert property (bus_master || pio_mode |=> !ram_sel && !ram_cs16)
		else $error("shared ram decoded outside shared mode");

	a_rom_nosize: assert property (!boot_rom_size_field[3] |=> !rom_sel)
		else $error("boot rom selected with no size");

	a_ram_nosize: assert property (!shared_ram_size_field[3] |=> !ram_sel)
		else $error("shared ram selected with no size");

	a_activate_bit: assert property (cfg_we && !ee_we && cfg_index == IRCD_ACTIVATE |=>
		active == $past(cfg_wdata[0]))
		else $error("activate bit not taken");

	a_ee_preload: assert property (ee_we && ee_index == IRCD_CHAN_SELECT |=>
		chan_select == $past(ee_data[2:0]))
		else $error("preload of channel field lost");

endmodule

// ==== tb/ircd_isa_pins.sv ====
// ISA side pin model: resolves the IRQ and DRQ wires seen by the host
`timescale 1ns/10ps
module ircd_isa_pins #(
	parameter logic IRQ_PULL = 1'b1,
	parameter logic DRQ_PULL = 1'b0
) (
	input  wire logic [15:0] irq_out,   // IRQ levels from device
	input  wire logic [15:0] irq_oe_n,  // IRQ enables, low drives
	input  wire logic [7:0]  drq_out,   // DRQ levels from device
	input  wire logic [7:0]  drq_oe_n,  // DRQ enables, low drives
	output logic      [15:0] irq_pin,   // Resolved IRQ wires
	output logic      [7:0]  drq_pin    // Resolved DRQ wires
);
	// Released lines fall to the board pull, never the last driven value
	always_comb begin
		for (int i = 0; i < 16; i++)
			irq_pin[i] = irq_oe_n[i] ? IRQ_PULL : irq_out[i];
		for (int i = 0; i < 8; i++)
			drq_pin[i] = drq_oe_n[i] ? DRQ_PULL : drq_out[i];
	end
endmodule

// ==== tb/ircd_top_test.sv ====
// Self-checking bench for the resource configuration bank
`timescale 1ns/10ps
module ircd_top_test;
	import ircd_pkg::*;
	logic        mclk, nrst, cfg_we, cfg_re, ee_we, bus_master, pio_mode;
	logic        aen, mem_cycle, irq_req, dma_req;
	logic [7:0]  cfg_index, cfg_wdata, ee_index, ee_data, cfg_rdata;
	logic [19:0] sa;
	logic        io_sel, rom_sel, rom_cs16, ram_sel, ram_cs16, active;
	logic [15:0] irq_out, irq_oe_n, irq_pin, exp;
	logic [7:0]  drq_out, drq_oe_n, drq_pin;
	logic [2:0]  szc [4] = '{3'h7, 3'h6, 3'h4, 3'h0};
	int          err_count = 0;
	int          num_checks = 0;

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	ircd_top u_ircd_top (.mclk, .nrst, .cfg_index, .cfg_wdata, .cfg_we, .cfg_re, .cfg_rdata,
		.ee_index, .ee_data, .ee_we, .bus_master, .pio_mode, .sa, .aen, .mem_cycle, .irq_req,
		.dma_req, .io_sel, .rom_sel, .rom_cs16, .ram_sel, .ram_cs16, .irq_out, .irq_oe_n,
		.drq_out, .drq_oe_n, .active);

	ircd_isa_pins u_ircd_isa_pins (.irq_out, .irq_oe_n, .drq_out, .drq_oe_n, .irq_pin, .drq_pin);

	// ----------------------------------------------------------------
	// Access and compare tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
		num_checks++;
		if (seen !== want) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", what, want, seen);
		end
	endtask

	// Preload and host writes share one task; one idle cycle between writes
	task automatic wr(input logic ee, input logic [7:0] idx, input logic [7:0] d);
		@(negedge mclk);
		if (ee) begin
			ee_index = idx;
			ee_data = d;
			ee_we = 1'b1;
		end else begin
			cfg_index = idx;
			cfg_wdata = d;
			cfg_we = 1'b1;
		end
		@(negedge mclk);
		ee_we = 1'b0;
		cfg_we = 1'b0;
	endtask

	task automatic rd(input logic [7:0] idx, input logic [7:0] want, input string what);
		@(negedge mclk);
		cfg_index = idx;
		cfg_re = 1'b1;
		@(negedge mclk);
		cfg_re = 1'b0;
		check(what, {8'h00, cfg_rdata}, {8'h00, want});
	endtask

	// Selects and pin enables lag their causes by up to two edges
	task automatic settle;
		repeat (3) @(negedge mclk);
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		#100us;
		err_count++;
		$display("watchdog expired");
		wrap_up;
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		{nrst, cfg_we, cfg_re, ee_we, bus_master, pio_mode, aen, mem_cycle, irq_req, dma_req} = '0;
		{cfg_index, cfg_wdata, ee_index, ee_data} = '0;
		sa = '0;
		repeat (3) @(negedge mclk);
		nrst = 1'b1;
		rd(IRCD_IRQ_SELECT, 8'h03, "irq select");
		rd(IRCD_IRQ_KIND, 8'h02, "irq kind");
		rd(IRCD_CHAN_SELECT, 8'h04, "channel");
		rd(IRCD_IO_BASE_HI, IRCD_IO_HI_FIXED, "io base hi");
		rd(IRCD_BOOT_BASE_HI, IRCD_MEM_HI_FIXED, "rom base hi");
		rd(IRCD_SRAM_SIZE_HI, IRCD_SZ_HI_FIXED, "ram size hi");
		rd(8'h55, 8'h00, "unmapped");
		check("irq enables", irq_oe_n, 16'hffff);
		wr(0, IRCD_IRQ_KIND, 8'h03);
		rd(IRCD_IRQ_KIND, 8'h01, "level kind");
		wr(0, IRCD_IRQ_KIND, 8'h00);
		rd(IRCD_IRQ_KIND, 8'h02, "edge kind");
		$display("test reset and kind done");

		// Field 1001 selects 0x320
		wr(1, IRCD_IO_BASE_HI, 8'h01);
		wr(1, IRCD_IO_BASE_LO, 8'h20);
		rd(IRCD_IO_BASE_HI, 8'h03, "io base hi");
		rd(IRCD_IO_BASE_LO, 8'h20, "io base lo");
		sa = 20'h00320;
		settle;
		check("io before activate", io_sel, 16'h0);
		wr(0, IRCD_ACTIVATE, 8'h01);
		settle;
		check("io hit", io_sel, 16'h1);
		check("active pin", active, 16'h1);
		rd(IRCD_ACTIVATE, 8'h01, "activate");
		sa = 20'h00300;
		settle;
		check("io miss", io_sel, 16'h0);
		sa = 20'h00320;
		aen = 1'b1;
		settle;
		check("io during dma", io_sel, 16'h0);
		aen = 1'b0;
		$display("test io decode done");

		irq_req = 1'b1;
		for (int c = 0; c < 16; c++) begin
			wr(0, IRCD_IRQ_SELECT, 8'(c));
			settle;
			exp = (c inside {3, 4, 5, 9, 10, 11, 12, 15}) ? ~(16'h1 << c) : 16'hffff;
			check("irq enables", irq_oe_n, exp);
		end
		wr(0, IRCD_IRQ_SELECT, 8'h03);
		settle;
		check("edge pin", irq_pin, 16'hffff);
		irq_req = 1'b0;
		settle;
		check("edge idle pin", irq_pin, 16'hfff7);
		irq_req = 1'b1;
		wr(0, IRCD_IRQ_KIND, 8'h01);
		settle;
		check("level pin", irq_pin, 16'hfff7);
		irq_req = 1'b0;
		settle;
		check("level idle pin", irq_pin, 16'hffff);
		$display("test interrupt select done");

		wr(1, IRCD_CHAN_SELECT, 8'h05);
		rd(IRCD_CHAN_SELECT, 8'h05, "preload channel");
		// Host write in the preload cycle is lost
		@(negedge mclk);
		{ee_index, cfg_index} = {IRCD_CHAN_SELECT, IRCD_CHAN_SELECT};
		{ee_data, cfg_wdata} = {8'h03, 8'h06};
		{ee_we, cfg_we} = 2'b11;
		@(negedge mclk);
		{ee_we, cfg_we} = 2'b00;
		rd(IRCD_CHAN_SELECT, 8'h03, "preload wins");
		bus_master = 1'b1;
		dma_req = 1'b1;
		for (int c = 0; c < 8; c++) begin
			wr(0, IRCD_CHAN_SELECT, 8'(c));
			settle;
			exp = (c inside {3, 5, 6, 7}) ? {8'h00, ~(8'h1 << c)} : 16'h00ff;
			check("drq enables", drq_oe_n, exp);
			check("drq pins", drq_pin, (c inside {3, 5, 6, 7}) ? (16'h1 << c) : 16'h0000);
		end
		bus_master = 1'b0;
		settle;
		check("drq outside bus master", drq_oe_n, 16'h00ff);
		$display("test channel select done");

		// Both bases at the bottom of a 64K block, legal for every size
		mem_cycle = 1'b1;
		wr(0, IRCD_BOOT_BASE_HI, 8'h01);
		wr(0, IRCD_BOOT_BASE_LO, 8'h00);
		wr(0, IRCD_BOOT_SIZE_HI, 8'h01);
		wr(0, IRCD_BOOT_WIDE, 8'h02);
		wr(0, IRCD_SRAM_BASE_HI, 8'h00);
		wr(0, IRCD_SRAM_BASE_LO, 8'h00);
		wr(0, IRCD_SRAM_SIZE_HI, 8'h01);
		wr(0, IRCD_SRAM_WIDE, 8'h02);
		for (int k = 0; k < 4; k++) begin
			wr(0, IRCD_BOOT_SIZE_LO, {szc[k], 5'h00});
			wr(0, IRCD_SRAM_SIZE_LO, {szc[k], 5'h00});
			sa = 20'hd0000 + (20'h2000 << k) - 20'h2000;
			settle;
			check("rom top of window", rom_sel, 16'h1);
			check("rom wide", rom_cs16, 16'h1);
			check("ram top of window", ram_sel, 16'h1);
			check("ram wide", ram_cs16, 16'h1);
			sa = 20'hd0000 + (20'h2000 << k);
			settle;
			check("rom past window", rom_sel, 16'h0);
			if (k < 3)
				check("ram past window", ram_sel, 16'h0);
		end
		sa = 20'hc0000;
		settle;
		check("rom base bit3", rom_sel, 16'h0);
		sa = 20'hd0000;
		bus_master = 1'b1;
		settle;
		check("rom in bus master", rom_sel, 16'h1);
		check("rom narrow in bus master", rom_cs16, 16'h0);
		check("ram in bus master", ram_sel, 16'h0);
		bus_master = 1'b0;
		pio_mode = 1'b1;
		settle;
		check("ram in pio", ram_sel, 16'h0);
		pio_mode = 1'b0;
		wr(0, IRCD_BOOT_SIZE_HI, 8'h00);
		wr(0, IRCD_SRAM_SIZE_HI, 8'h00);
		settle;
		check("rom size off", rom_sel, 16'h0);
		check("ram size off", ram_sel, 16'h0);
		$display("test memory windows done");

		wr(0, IRCD_ACTIVATE, 8'h00);
		irq_req = 1'b1;
		bus_master = 1'b1;
		settle;
		check("irq released", irq_oe_n, 16'hffff);
		check("irq wires pulled", irq_pin, 16'hffff);
		check("drq released", drq_oe_n, 16'h00ff);
		check("drq wires pulled", drq_pin, 16'h0000);
		$display("test deactivate done");
		wrap_up;
	end
endmodule
